// file: design/smr_defs.svh
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH
`define SMR_OP_QOR 8'h6B
`define SMR_OP_QOR_L 8'h6C
`define SMR_OP_DUAL_IO_READ_CMD 8'hBB
`define SMR_OP_DUAL_IO_READ_CMD_L 8'hBC
`define SMR_OP_QUAD_IO_READ_CMD 8'hEB
`define SMR_OP_QUAD_IO_READ_CMD_L 8'hEC
`define SMR_OP_MODE_RST 8'hFF
`define SMR_MODE_KEEP 4'hA
`define SMR_REG_CFG 4'h0
`define SMR_REG_STAT 4'h4
`define SMR_REG_MADR 4'h8
`define SMR_REG_MDAT 4'hC
`define SMR_CFG_RST 8'h00
`define SMR_OPC_SER_CLK 6'h08
`define SMR_OPC_QPI_CLK 6'h02
`define SMR_DUAL_IO_READ_CMD_MODE_CLK 6'h04
`define SMR_QUAD_IO_READ_CMD_MODE_CLK 6'h02
`define SMR_MEM_DEPTH 256
`endif

// file: design/smr_pkg.sv
package smr_pkg;
	typedef enum logic [2:0] {PH_IDLE, PH_OPC, PH_ADR, PH_MOD, PH_DUM, PH_DAT, PH_SKIP} smr_phase_t;
	typedef enum logic [1:0] {K_NONE, K_QOR, K_DUAL_IO_READ_CMD, K_QUAD_IO_READ_CMD} smr_kind_t;
	typedef struct packed {
		logic [3:0] latency_code_field;
		logic quad_peripheral_mode_bit;
		logic quad_enable_bit;
		logic quad_peripheral_enable_bit;
		logic address_length_bit;
	} smr_cfg_t;
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic [3:0] io;
	} smr_pins_t;
	typedef struct packed {
		smr_pins_t s1;
		smr_pins_t s2;
	} smr_sync_t;
	typedef struct packed {
		smr_phase_t phase;
		smr_kind_t kind;
		smr_kind_t cont;
		logic [5:0] cnt;
		logic [7:0] sr;
		logic [31:0] addr;
		logic long;
		logic mode_seen;
		logic mode_ok;
		logic [7:0] dout;
		logic [1:0] dcnt;
		logic sck_d;
		logic cs_d;
		logic [3:0] io_out;
		logic [3:0] io_oe_n;
		smr_cfg_t cfg;
		logic [7:0] madr;
		logic [31:0] rdata;
		logic waitreq;
	} smr_state_t;
endpackage

// file: design/smr_sync.sv
`timescale 1ns/100ps
module smr_sync #(
	parameter smr_pkg::smr_pins_t RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire smr_pkg::smr_pins_t d,
	output smr_pkg::smr_pins_t q
);
	smr_pkg::smr_sync_t s;
	smr_pkg::smr_sync_t next_s;

	// first stage feeds only the second
	always_comb begin
		next_s.s1 = d;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= {RST_VAL, RST_VAL};
		end else begin
			s <= next_s;
		end
	end

	assign q = s.s2;
endmodule

// file: design/smr_flash_read.sv
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "smr_defs.svh"
// Summary of operation
// - 6Bh is quad-output read, 3 or 4 address bytes per length bit; 6Ch 4 bytes.
// - quad-output read inserts latency-code dummy cycles after the last address bit.
// - data lines are ignored during quad-output read dummy cycles.
// - quad reads return one nibble per clock, changing on falling edges.
// - read starts anywhere, address increments per byte and wraps to zero.
// - BBh is dual-I/O read with 3 or 4 address bytes; BCh 4 bytes.
// - dual-I/O address arrives two bits per rising edge on the two low lines.
// - dual-I/O data leaves two bits per clock on the low lines, falling edge.
// - first dual-I/O read: opcode, address, four mode clocks, then latency.
// - dual-I/O read inserts latency-code dummy cycles after mode, lines ignored.
// - dual-I/O mode nibble A keeps continuous mode; next select starts at address.
// - the low mode nibble is ignored and may be left undriven.
// - other mode nibble in dual continuous read leaves that mode at deselect.
// - the mode-reset command leaves dual or quad continuous mode.
// - EBh is quad-I/O read with 3 or 4 address bytes; ECh 4 bytes.
// - quad-I/O opcodes accepted only with quad enable or quad-peripheral enable set; continuous frames are not gated.
// - quad-I/O address arrives four bits per clock on all four lines.
// - quad-I/O read has two mode clocks, then latency-code dummy cycles.
// - quad-I/O mode nibble A keeps continuous mode; other values leave it.
// - in quad-peripheral mode the opcode arrives four bits per rising edge.
// - otherwise every opcode arrives one bit per rising edge on the input line.
// - the length bit makes legacy 3-byte opcodes take a 4-byte address.
// - deselect ends any read at any point in the data phase.
module smr_flash_read (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic [3:0] IO_IN,
	output logic [3:0] IO_OUT,
	output logic [3:0] IO_OE_N,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST
);
	smr_pkg::smr_state_t s;
	smr_pkg::smr_state_t n;
	smr_pkg::smr_pins_t pin_raw;
	smr_pkg::smr_pins_t p;
	logic [7:0] mem [0:`SMR_MEM_DEPTH-1];
	logic mem_we;
	logic rise;
	logic fall;
	logic [31:0] op_word;
	logic [31:0] mod_word;
	logic [7:0] op_byte;
	logic op_done;
	logic req;

	// shift lanes in, highest lane carries the most significant bit
	function automatic logic [31:0] shin(input logic [31:0] v, input logic [3:0] io,
		input logic [2:0] w);
		case (w)
			3'h1: shin = {v[30:0], io[0]};
			3'h2: shin = {v[29:0], io[1:0]};
			default: shin = {v[27:0], io};
		endcase
	endfunction

	function automatic logic [2:0] aw(input smr_pkg::smr_kind_t k);
		case (k)
			smr_pkg::K_QOR: aw = 3'h1;
			smr_pkg::K_DUAL_IO_READ_CMD: aw = 3'h2;
			default: aw = 3'h4;
		endcase
	endfunction

	function automatic logic [5:0] adr_clk(input smr_pkg::smr_kind_t k, input logic lng);
		case (k)
			smr_pkg::K_QOR: adr_clk = lng ? 6'h20 : 6'h18;
			smr_pkg::K_DUAL_IO_READ_CMD: adr_clk = lng ? 6'h10 : 6'h0C;
			default: adr_clk = lng ? 6'h08 : 6'h06;
		endcase
	endfunction

	assign pin_raw = '{sck: SCK, cs_n: CS_N, io: IO_IN};

	smr_sync #(
		.RST_VAL('{sck: 1'b0, cs_n: 1'b1, io: 4'h0})
	) u_sync (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.d(pin_raw),
		.q(p)
	);

	assign rise = p.sck & ~s.sck_d;
	assign fall = ~p.sck & s.sck_d;
	assign op_word = shin({24'h000000, s.sr}, p.io, s.cfg.quad_peripheral_mode_bit ? 3'h4 : 3'h1);
	assign mod_word = shin({24'h000000, s.sr}, p.io, aw(s.kind));
	assign op_byte = op_word[7:0];
	assign op_done = rise & ~p.cs_n & ~s.cs_d & (s.phase == smr_pkg::PH_OPC) & (s.cnt == 6'h01);
	assign req = AVS_READ | AVS_WRITE;

	always_comb begin
		logic [7:0] b;
		b = 8'h00;
		n = s;
		mem_we = 1'b0;
		n.sck_d = p.sck;
		n.cs_d = p.cs_n;
		if (p.cs_n) begin
			n.phase = smr_pkg::PH_IDLE;
			n.io_oe_n = 4'hF;
			if (!s.cs_d) begin
				n.mode_seen = 1'b0;
				if (s.mode_seen) begin
					n.cont = s.mode_ok ? s.kind : smr_pkg::K_NONE;
				end
				// mode reset inside continuous frame
				// an all-ones address cut short before data looks the same
				if (s.cont != smr_pkg::K_NONE && s.sr == 8'hFF
					&& (s.phase == smr_pkg::PH_ADR || s.phase == smr_pkg::PH_MOD)) begin
					n.cont = smr_pkg::K_NONE;
				end
			end
		end else if (s.cs_d) begin
			n.addr = 32'h0;
			n.sr = 8'h00;
			if (s.cont != smr_pkg::K_NONE) begin
				n.kind = s.cont;
				n.phase = smr_pkg::PH_ADR;
				n.cnt = adr_clk(s.cont, s.long);
			end else begin
				n.phase = smr_pkg::PH_OPC;
				n.cnt = s.cfg.quad_peripheral_mode_bit ? `SMR_OPC_QPI_CLK : `SMR_OPC_SER_CLK;
			end
		end else begin
			case (s.phase)
				smr_pkg::PH_OPC: begin
					if (rise) begin
						n.sr = op_byte;
						n.cnt = s.cnt - 6'h01;
					end
					if (op_done) begin
						n.phase = smr_pkg::PH_ADR;
						n.long = 1'b1;
						case (op_byte)
							`SMR_OP_QOR: begin
								n.kind = smr_pkg::K_QOR;
								n.long = s.cfg.address_length_bit;
							end
							`SMR_OP_QOR_L: n.kind = smr_pkg::K_QOR;
							`SMR_OP_DUAL_IO_READ_CMD: begin
								n.kind = smr_pkg::K_DUAL_IO_READ_CMD;
								n.long = s.cfg.address_length_bit;
							end
							`SMR_OP_DUAL_IO_READ_CMD_L: n.kind = smr_pkg::K_DUAL_IO_READ_CMD;
							`SMR_OP_QUAD_IO_READ_CMD: begin
								n.kind = smr_pkg::K_QUAD_IO_READ_CMD;
								n.long = s.cfg.address_length_bit;
							end
							`SMR_OP_QUAD_IO_READ_CMD_L: n.kind = smr_pkg::K_QUAD_IO_READ_CMD;
							default: n.phase = smr_pkg::PH_SKIP;
						endcase
						if (n.phase == smr_pkg::PH_ADR && n.kind == smr_pkg::K_QUAD_IO_READ_CMD
							&& !(s.cfg.quad_enable_bit | s.cfg.quad_peripheral_enable_bit)) begin
							n.phase = smr_pkg::PH_SKIP;
						end
						if (op_byte == `SMR_OP_MODE_RST) begin
							n.cont = smr_pkg::K_NONE;
						end
						n.cnt = adr_clk(n.kind, n.long);
					end
				end
				smr_pkg::PH_ADR: begin
					if (rise) begin
						n.addr = shin(s.addr, p.io, aw(s.kind));
						n.sr = {s.sr[6:0], p.io[0]};
						n.cnt = s.cnt - 6'h01;
						if (s.cnt == 6'h01) begin
							if (s.kind == smr_pkg::K_QOR) begin
								n.phase = smr_pkg::PH_DUM;
								n.cnt = {2'b00, s.cfg.latency_code_field};
							end else begin
								n.phase = smr_pkg::PH_MOD;
								n.cnt = (s.kind == smr_pkg::K_DUAL_IO_READ_CMD) ? `SMR_DUAL_IO_READ_CMD_MODE_CLK
									: `SMR_QUAD_IO_READ_CMD_MODE_CLK;
							end
						end
					end
				end
				smr_pkg::PH_MOD: begin
					if (rise) begin
						n.sr = mod_word[7:0];
						n.cnt = s.cnt - 6'h01;
						if (s.cnt == 6'h01) begin
							n.mode_seen = 1'b1;
							n.mode_ok = (mod_word[7:4] == `SMR_MODE_KEEP);
							n.phase = smr_pkg::PH_DUM;
							n.cnt = {2'b00, s.cfg.latency_code_field};
						end
					end
				end
				smr_pkg::PH_DUM, smr_pkg::PH_DAT: begin
					if (fall) begin
						if (s.phase == smr_pkg::PH_DUM && s.cnt != 6'h00) begin
							n.cnt = s.cnt - 6'h01;
						end else if (s.phase == smr_pkg::PH_DAT && s.dcnt != 2'h0) begin
							n.io_out = (s.kind == smr_pkg::K_DUAL_IO_READ_CMD) ? {2'b00, s.dout[7:6]}
								: s.dout[7:4];
							n.dout = (s.kind == smr_pkg::K_DUAL_IO_READ_CMD) ? {s.dout[5:0], 2'b00}
								: {s.dout[3:0], 4'h0};
							n.dcnt = s.dcnt - 2'h1;
						end else begin
							// increment and wrap per address length
							if (s.phase == smr_pkg::PH_DAT) begin
								n.addr = s.long ? s.addr + 32'h1 : {8'h00, s.addr[23:0] + 24'h1};
							end
							b = mem[n.addr[7:0]];
							n.phase = smr_pkg::PH_DAT;
							if (s.kind == smr_pkg::K_DUAL_IO_READ_CMD) begin
								n.io_out = {2'b00, b[7:6]};
								n.dout = {b[5:0], 2'b00};
								n.dcnt = 2'h3;
								n.io_oe_n = 4'hC;
							end else begin
								n.io_out = b[7:4];
								n.dout = {b[3:0], 4'h0};
								n.dcnt = 2'h1;
								n.io_oe_n = 4'h0;
							end
						end
					end
				end
				default: begin
					n.io_oe_n = 4'hF;
				end
			endcase
		end
		// register slave: one wait cycle, then answer
		n.waitreq = ~(req & s.waitreq);
		if (AVS_READ & s.waitreq) begin
			case (AVS_ADDRESS)
				`SMR_REG_CFG: n.rdata = {24'h000000, s.cfg};
				`SMR_REG_STAT: n.rdata = {26'h0, s.mode_ok, s.phase, s.cont};
				`SMR_REG_MADR: n.rdata = {24'h000000, s.madr};
				`SMR_REG_MDAT: n.rdata = {24'h000000, mem[s.madr]};
				default: n.rdata = 32'h00000000;
			endcase
		end
		if (AVS_WRITE & ~s.waitreq) begin
			case (AVS_ADDRESS)
				`SMR_REG_CFG: n.cfg = smr_pkg::smr_cfg_t'(AVS_WRITEDATA[7:0]);
				`SMR_REG_MADR: n.madr = AVS_WRITEDATA[7:0];
				`SMR_REG_MDAT: begin
					mem_we = 1'b1;
					n.madr = s.madr + 8'h01;
				end
				default: n.madr = s.madr;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			s <= '0;
			s.cs_d <= 1'b1;
			s.io_oe_n <= 4'hF;
			s.waitreq <= 1'b1;
			s.cfg <= smr_pkg::smr_cfg_t'(`SMR_CFG_RST);
		end else begin
			s <= n;
		end
	end

	// array image loads through the register port only
	always_ff @(posedge CLK_SYS) begin
		if (mem_we) begin
			mem[s.madr] <= AVS_WRITEDATA[7:0];
		end
	end

	assign IO_OUT = s.io_out;
	assign IO_OE_N = s.io_oe_n;
	assign AVS_READDATA = s.rdata;
	assign AVS_WAITREQUEST = s.waitreq;

	a_desel_hiz: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N) p.cs_n |=> (IO_OE_N == 4'hF))
		else $error("outputs driven after deselect");

	a_quad_io_read_cmd_gate: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(op_done && (op_byte == `SMR_OP_QUAD_IO_READ_CMD || op_byte == `SMR_OP_QUAD_IO_READ_CMD_L)
		&& !(s.cfg.quad_enable_bit || s.cfg.quad_peripheral_enable_bit))
		|=> (s.phase == smr_pkg::PH_SKIP))
		else $error("quad io read accepted without quad enable");

	a_quad_lanes: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_DAT && s.kind != smr_pkg::K_DUAL_IO_READ_CMD) |-> (IO_OE_N == 4'h0))
		else $error("quad data not on four lines");

	a_dual_lanes: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_DAT && s.kind == smr_pkg::K_DUAL_IO_READ_CMD) |-> (IO_OE_N == 4'hC))
		else $error("dual data not on two low lines");

	a_qor_dummy_hiz: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_DUM && s.kind == smr_pkg::K_QOR) |-> (IO_OE_N == 4'hF))
		else $error("lines driven in quad output dummy");

	a_dual_io_read_cmd_dummy_hiz: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_DUM && s.kind == smr_pkg::K_DUAL_IO_READ_CMD) |-> (IO_OE_N == 4'hF))
		else $error("lines driven in dual dummy");

	a_addr_inc: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_DAT && fall && s.dcnt == 2'h0 && !p.cs_n && s.long)
		|=> (s.addr == $past(s.addr) + 32'h1))
		else $error("address not incremented after byte");

	a_cont_keep: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(p.cs_n && !s.cs_d && s.mode_seen && s.mode_ok) |=> (s.cont == $past(s.kind)))
		else $error("continuous mode not kept");

	a_cont_drop: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(p.cs_n && !s.cs_d && s.mode_seen && !s.mode_ok) |=> (s.cont == smr_pkg::K_NONE))
		else $error("continuous mode not left");

	a_mode_reset: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		((op_done && op_byte == `SMR_OP_MODE_RST) || (p.cs_n && !s.cs_d
		&& s.cont != smr_pkg::K_NONE && s.sr == 8'hFF
		&& (s.phase == smr_pkg::PH_ADR || s.phase == smr_pkg::PH_MOD)))
		|=> (s.cont == smr_pkg::K_NONE))
		else $error("mode reset ignored");

	a_addr_wrap: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_DAT && fall && s.dcnt == 2'h0 && !p.cs_n && !s.long)
		|=> (s.addr == {8'h00, $past(s.addr[23:0]) + 24'h1}))
		else $error("short address not wrapped");

	a_qor_latency: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_ADR && s.kind == smr_pkg::K_QOR && rise && s.cnt == 6'h01
		&& !p.cs_n && !s.cs_d)
		|=> (s.phase == smr_pkg::PH_DUM && s.cnt == {2'b00, s.cfg.latency_code_field}))
		else $error("wrong dummy count");

	a_opc_width: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(!p.cs_n && s.cs_d && s.cont == smr_pkg::K_NONE)
		|=> (s.cnt == ($past(s.cfg.quad_peripheral_mode_bit) ? 6'h02 : 6'h08)))
		else $error("wrong opcode clock count");

	a_dual_addr: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_ADR && s.kind == smr_pkg::K_DUAL_IO_READ_CMD && rise && !p.cs_n && !s.cs_d)
		|=> (s.addr[1:0] == $past(p.io[1:0])))
		else $error("dual address lanes wrong");

	a_quad_addr: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_ADR && s.kind == smr_pkg::K_QUAD_IO_READ_CMD && rise && !p.cs_n && !s.cs_d)
		|=> (s.addr[3:0] == $past(p.io)))
		else $error("quad address lanes wrong");

	a_quad_io_read_cmd_mode: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_ADR && s.kind == smr_pkg::K_QUAD_IO_READ_CMD && rise && s.cnt == 6'h01
		&& !p.cs_n && !s.cs_d) |=> (s.phase == smr_pkg::PH_MOD && s.cnt == 6'h02))
		else $error("quad mode length wrong");

	a_dual_io_read_cmd_mode: assert property (
		@(posedge CLK_SYS) disable iff (!RST_N)
		(s.phase == smr_pkg::PH_ADR && s.kind == smr_pkg::K_DUAL_IO_READ_CMD && rise && s.cnt == 6'h01
		&& !p.cs_n && !s.cs_d) |=> (s.phase == smr_pkg::PH_MOD && s.cnt == 6'h04))
		else $error("dual mode length wrong");
endmodule

// file: tb/smr_host_model.sv
`timescale 1ns/100ps
module smr_host_model (
	input wire logic clk,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_n,
	output logic sck,
	output logic cs_n,
	output logic [3:0] io_w
);
	logic [3:0] en = 4'h0;
	logic [3:0] dq = 4'h0;
	logic [3:0] smp;
	logic [3:0] oes;
	logic [7:0] sh;
	logic [11:0] val = 12'h000;
	logic stb = 1'b0;
	logic drove = 1'b0;
	logic clash = 1'b0;
	initial sck = 1'b0;
	initial cs_n = 1'b1;
	// released lines show the inverse of the last value, so no level is a lucky guess
	assign io_w = (~io_oe_n & io_out) | (io_oe_n & en & dq) | (io_oe_n & ~en & ~dq);
	always @(posedge clk) begin
		if (io_oe_n !== 4'hF) drove <= 1'b1;
		if ((~io_oe_n & en) !== 4'h0) clash <= 1'b1;
	end
	task automatic sel();
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic desel();
		@(posedge clk);
		stb <= 1'b0;
		en <= 4'h0;
		cs_n <= 1'b1;
		// deselect must reach the device before the next frame or status read
		repeat (4) @(posedge clk);
	endtask
	// data set while low, taken at rise
	task automatic clk1(input logic [3:0] d, input int w, input bit drv);
		en <= drv ? 4'(4'hF >> (4 - w)) : 4'h0;
		if (drv) dq <= d;
		@(posedge clk);
		stb <= 1'b0;
		repeat (3) @(posedge clk);
		smp = io_w;
		oes = io_oe_n;
		sck <= 1'b1;
		repeat (4) @(posedge clk);
		sck <= 1'b0;
	endtask
	// top bits first, high bits on high lines
	task automatic cyc(input int n, input int w, input logic [31:0] v, input bit drv);
		for (int i = 0; i < n; i++) begin
			clk1(4'(v[31:28] >> (4 - w)), w, drv);
			v = v << w;
		end
	endtask
	task automatic rd(input int n, input int w);
		int c;
		c = 0;
		for (int i = 0; i < n; i++) begin
			clk1(4'h0, w, 1'b0);
			sh = (w == 2) ? {sh[5:0], smp[1:0]} : {sh[3:0], smp};
			c = c + w;
			if (c == 8) begin
				c = 0;
				val <= {oes, sh};
				stb <= 1'b1;
			end
		end
	endtask
endmodule

// file: tb/smr_flash_read_tb.sv
`timescale 1ns/100ps
`include "smr_defs.svh"
module smr_flash_read_tb;
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic [3:0] AVS_ADDRESS = 4'h0;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic SCK;
	logic CS_N;
	logic [3:0] IO_W;
	logic [3:0] IO_OUT;
	logic [3:0] IO_OE_N;
	logic [7:0] mem [256];
	logic [63:0] q [$];
	logic [31:0] a;
	int failures = 0;
	int cmp_count = 0;
	always #12.5 CLK_SYS = ~CLK_SYS;
	smr_flash_read DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SCK(SCK), .CS_N(CS_N),
		.IO_IN(IO_W), .IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
	smr_host_model host (.clk(CLK_SYS), .io_out(IO_OUT), .io_oe_n(IO_OE_N), .sck(SCK),
		.cs_n(CS_N), .io_w(IO_W));
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
			failures++;
		end
	endtask
	// a read notes {mask, value}; writedata carries the value meanwhile, harmless
	task automatic av(input bit wr, input logic [3:0] ad, input logic [31:0] d,
		input logic [31:0] m);
		int k;
		@(posedge CLK_SYS);
		AVS_ADDRESS <= ad;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		if (!wr) q.push_back({m, d});
		for (k = 0; k < 20; k++) begin
			@(posedge CLK_SYS);
			if (AVS_WAITREQUEST === 1'b0) break;
		end
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		if (k == 20) begin
			failures++;
			close_out();
		end
	endtask
	always @(posedge CLK_SYS) begin : mon
		logic [31:0] g;
		logic [63:0] e;
		if ((AVS_READ && AVS_WAITREQUEST === 1'b0) || host.stb) begin
			g = host.stb ? {20'h0, host.val} : AVS_READDATA;
			e = (q.size() > 0) ? q.pop_front() : 64'h1;
			chk(g & e[63:32], e[31:0]);
		end
	end
	task automatic cmd(input logic [7:0] cf, input logic [7:0] op, input int kd,
		input logic [31:0] ad, input logic [7:0] md, input int n, input bit cont);
		int aw;
		int ow;
		bit lg;
		aw = (kd == 0) ? 1 : (kd == 1) ? 2 : 4;
		ow = (kd == 1) ? 2 : 4;
		lg = cf[0] || op[3:0] == 4'hC;
		av(1'b1, `SMR_REG_CFG, {24'h0, cf}, 32'h0);
		host.sel();
		if (!cont) host.cyc(cf[3] ? 2 : 8, cf[3] ? 4 : 1, {op, 24'h0}, 1'b1);
		host.cyc(lg ? 32 / aw : 24 / aw, aw, lg ? ad : {ad[23:0], 8'h00}, 1'b1);
		if (kd == 1) begin
			host.cyc(2, 2, {md, 24'h0}, 1'b1);
			host.cyc(2, 2, 32'h0, 1'b0);
		end
		if (kd == 2) begin
			host.cyc(1, 4, {md, 24'h0}, 1'b1);
			host.cyc(1, 4, 32'h0, 1'b0);
		end
		host.cyc(int'(cf[7:4]), 4, 32'h0, 1'b0);
		for (int i = 0; i < n; i++) begin
			q.push_back({32'hFFF, 20'h0, (kd == 1) ? 4'hC : 4'h0, mem[8'(ad[7:0] + i)]});
		end
		host.rd(n * 8 / ow, ow);
		host.desel();
		repeat (5) @(posedge CLK_SYS);
		chk({28'h0, IO_OE_N}, 32'h0000000F);
	endtask
	initial begin
		void'($urandom(32'h0271));
		repeat (20) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		repeat (4) @(posedge CLK_SYS);
		av(1'b0, `SMR_REG_CFG, 32'h0, 32'hFFFFFFFF);
		av(1'b0, `SMR_REG_STAT, 32'h0, 32'hFFFFFFFF);
		av(1'b1, 4'h2, 32'h5A, 32'h0);
		av(1'b0, 4'h2, 32'h0, 32'hFFFFFFFF);
		av(1'b1, `SMR_REG_MADR, 32'h0, 32'h0);
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'($urandom);
			av(1'b1, `SMR_REG_MDAT, {24'h0, mem[i]}, 32'h0);
		end
		av(1'b1, `SMR_REG_MADR, 32'h10, 32'h0);
		av(1'b0, `SMR_REG_MDAT, {24'h0, mem[16]}, 32'hFFFFFFFF);
		a = $urandom;
		cmd(8'h20, `SMR_OP_QOR, 0, 32'h00FFFFFE, 8'h00, 3, 1'b0);
		cmd(8'h00, `SMR_OP_QOR_L, 0, a, 8'h00, 2, 1'b0);
		cmd(8'h11, `SMR_OP_DUAL_IO_READ_CMD, 1, a + 1, 8'hA3, 2, 1'b0);
		av(1'b0, `SMR_REG_STAT, 32'h2, 32'h3);
		cmd(8'h11, `SMR_OP_DUAL_IO_READ_CMD, 1, a + 7, 8'h5C, 2, 1'b1);
		av(1'b0, `SMR_REG_STAT, 32'h0, 32'h3);
		cmd(8'h11, `SMR_OP_DUAL_IO_READ_CMD, 1, a + 3, 8'hA0, 1, 1'b0);
		host.sel();
		host.cyc(8, 1, 32'hFFFFFFFF, 1'b1);
		host.desel();
		av(1'b0, `SMR_REG_STAT, 32'h0, 32'h3);
		host.sel();
		host.cyc(8, 1, 32'hFFFFFFFF, 1'b1);
		host.desel();
		av(1'b0, `SMR_REG_STAT, 32'h0, 32'h3);
		cmd(8'h30, `SMR_OP_DUAL_IO_READ_CMD_L, 1, $urandom, 8'h50, 2, 1'b0);
		cmd(8'h04, `SMR_OP_QUAD_IO_READ_CMD, 2, a, 8'hA5, 2, 1'b0);
		av(1'b0, `SMR_REG_STAT, 32'h3, 32'h3);
		cmd(8'h04, `SMR_OP_QUAD_IO_READ_CMD, 2, a + 9, 8'hA6, 3, 1'b1);
		host.sel();
		host.cyc(8, 4, 32'hFFFFFFFF, 1'b1);
		host.desel();
		av(1'b0, `SMR_REG_STAT, 32'h0, 32'h3);
		cmd(8'h1A, `SMR_OP_QUAD_IO_READ_CMD_L, 2, $urandom, 8'h00, 2, 1'b0);
		av(1'b1, `SMR_REG_CFG, 32'h0, 32'h0);
		host.drove = 1'b0;
		host.sel();
		host.cyc(8, 1, {`SMR_OP_QUAD_IO_READ_CMD, 24'h0}, 1'b1);
		host.cyc(8, 4, $urandom, 1'b1);
		host.cyc(4, 4, 32'h0, 1'b0);
		host.desel();
		chk({31'h0, host.drove}, 32'h0);
		av(1'b0, `SMR_REG_STAT, 32'h0, 32'h3);
		chk({31'h0, host.clash}, 32'h0);
		close_out();
	end
endmodule
